/* cvc_crtc.sv */
// crt controller second half: row scan, cursor, vertical timing, addressing, host registers
//
// Overview of operation
// - row scan counter loads the preset value at each frame wrap past vertical total
// - max scan field is scan lines per character row minus one
// - row scan advances per horizontal retrace, clears on reaching max scan
// - cursor hidden when off bit set or start row exceeds end row
// - cursor shown from start row up to end field minus one
// - cursor delayed right by skew field character clocks
// - 16-bit start address plus display origin gives refresh start
// - 16-bit cursor location; cursor shown where refresh address matches
// - vertical retrace starts at 9-bit line value with overflow ninth bit
// - vertical retrace ends when low four line bits match end field
// - interrupt pin floats when disable bit set, else fires on retrace
// - interrupt pending cleared while arm bit low; handler toggles low-high
// - light pen strobe captures refresh address, read at indices 10h/11h
// - vertical display ends after 9-bit display end value plus one lines
// - next row start equals current row start plus row pitch
// - underline drawn on row scan equal to underline field
// - vertical blank starts at 9-bit value, ends on low five bits match
// - mode bit 7 low holds both retrace outputs cleared
// - word mode drives address bit 0 from counter bit 15, or from bit 13 when mode bit 5 is low
// - mode bits halve address counter and vertical counter clocks
// - mode bit 0 low puts row scan bit 0 on address bit 13 while display is enabled
// - line compare match clears address generator and row start
// - index port selects which register the data port reaches
// - overflow register supplies ninth bits of vertical values
// - status bit 0 high while either retrace output (gated by mode bit 7) is active
`timescale 1ns/1ps

module cvc_crtc (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    input  wire cvc_pkg::cvc_host_req_t host_req,
    output logic [7:0]                 io_rdata,
    output logic [7:0]                 status_o,
    input  wire logic                  hretrace_start,
    input  wire logic                  hretrace_in,
    input  wire logic                  hdisp_in,
    input  wire logic [15:0]           disp_origin,
    input  wire logic                  pen_strobe,
    output cvc_pkg::cvc_video_t        video,
    output logic [15:0]                mem_addr,
    output logic                       irq_o,
    output logic                       irq_oe
);

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    function automatic logic [8:0] cat9(input logic hi, input logic [7:0] lo);
        cat9 = {hi, lo};
    endfunction

    // ------------------------------------------------------------
    // host register file
    // ------------------------------------------------------------
    logic [7:0]  regs_q   [cvc_pkg::REG_COUNT];
    logic [7:0]  regs_d   [cvc_pkg::REG_COUNT];
    logic [4:0]  index_q, index_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [15:0] pen_addr_q, pen_addr_d;
    logic        pen_flag_q, pen_flag_d;
    logic        pen_s1_q, pen_s2_q, pen_s3_q;
    logic        pen_edge;
    logic [15:0] ma_q;

    assign pen_edge = pen_s2_q & ~pen_s3_q;

    always_comb begin
        regs_d     = regs_q;
        index_d    = index_q;
        rdata_d    = rdata_q;
        pen_addr_d = pen_addr_q;
        pen_flag_d = pen_flag_q;
        if (host_req.idx_wr) begin
            index_d = host_req.wdata[4:0];
        end
        if (host_req.dat_wr && index_q <= cvc_pkg::IDX_LINE_COMPARE) begin
            regs_d[index_q] = host_req.wdata;
        end
        if (host_req.dat_rd) begin
            // write-only registers read back as zero
            if (index_q == cvc_pkg::IDX_START_HIGH || index_q == cvc_pkg::IDX_START_LOW ||
                index_q == cvc_pkg::IDX_CURSOR_HIGH || index_q == cvc_pkg::IDX_CURSOR_LOW) begin
                rdata_d = regs_q[index_q];
            end else if (index_q == cvc_pkg::IDX_PEN_HIGH) begin
                rdata_d = pen_addr_q[15:8];
            end else if (index_q == cvc_pkg::IDX_PEN_LOW) begin
                rdata_d = pen_addr_q[7:0];
                pen_flag_d = 1'b0;
            end else begin
                rdata_d = cvc_pkg::REG_RESET;
            end
        end
        if (pen_edge) begin
            pen_addr_d = ma_q;
            pen_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < cvc_pkg::REG_COUNT; i++) begin
                regs_q[i] <= cvc_pkg::REG_RESET;
            end
            index_q    <= 5'h00;
            rdata_q    <= cvc_pkg::REG_RESET;
            pen_addr_q <= cvc_pkg::ADDR_RESET;
            pen_flag_q <= 1'b0;
            pen_s1_q   <= 1'b0;
            pen_s2_q   <= 1'b0;
            pen_s3_q   <= 1'b0;
        end else if (clk_en) begin
            regs_q     <= regs_d;
            index_q    <= index_d;
            rdata_q    <= rdata_d;
            pen_addr_q <= pen_addr_d;
            pen_flag_q <= pen_flag_d;
            pen_s1_q   <= pen_strobe;
            pen_s2_q   <= pen_s1_q;
            pen_s3_q   <= pen_s2_q;
        end
    end

    assign io_rdata = rdata_q;

    // ------------------------------------------------------------
    // decoded fields
    // ------------------------------------------------------------
    logic [7:0]  ovf, mode;
    logic [8:0]  vtotal, vret_start, vdisp_end, vblank_start, line_cmp;
    logic [4:0]  max_scan, cur_start, cur_end, ul_row;
    logic [15:0] start_addr, cur_loc;
    logic [1:0]  cur_skew;
    logic        irq_arm, irq_dis;

    assign ovf          = regs_q[cvc_pkg::IDX_OVERFLOW];
    assign mode         = regs_q[cvc_pkg::IDX_MODE];
    assign vtotal       = cat9(ovf[cvc_pkg::OVF_VT_BIT], regs_q[cvc_pkg::IDX_VERT_TOTAL]);
    assign vret_start   = cat9(ovf[cvc_pkg::OVF_VRS_BIT], regs_q[cvc_pkg::IDX_VRET_START]);
    assign vdisp_end    = cat9(ovf[cvc_pkg::OVF_VDE_BIT], regs_q[cvc_pkg::IDX_VDISP_END]);
    assign vblank_start = cat9(ovf[cvc_pkg::OVF_VBS_BIT], regs_q[cvc_pkg::IDX_VBLANK_START]);
    assign line_cmp     = cat9(ovf[cvc_pkg::OVF_LC_BIT], regs_q[cvc_pkg::IDX_LINE_COMPARE]);
    assign max_scan     = regs_q[cvc_pkg::IDX_MAX_SCAN][4:0];
    assign cur_start    = regs_q[cvc_pkg::IDX_CURSOR_START][4:0];
    assign cur_end      = regs_q[cvc_pkg::IDX_CURSOR_END][4:0];
    assign cur_skew     = regs_q[cvc_pkg::IDX_CURSOR_END][cvc_pkg::SKEW_LSB +: 2];
    assign ul_row       = regs_q[cvc_pkg::IDX_UNDERLINE][4:0];
    assign start_addr   = {regs_q[cvc_pkg::IDX_START_HIGH], regs_q[cvc_pkg::IDX_START_LOW]};
    assign cur_loc      = {regs_q[cvc_pkg::IDX_CURSOR_HIGH], regs_q[cvc_pkg::IDX_CURSOR_LOW]};
    assign irq_arm      = regs_q[cvc_pkg::IDX_VRET_END][cvc_pkg::IRQ_ARM_BIT];
    assign irq_dis      = regs_q[cvc_pkg::IDX_VRET_END][cvc_pkg::IRQ_DISABLE_BIT];

    // ------------------------------------------------------------
    // vertical timing and address generation
    // ------------------------------------------------------------
    logic [8:0]  vcnt_q, vcnt_d;
    logic [4:0]  row_q, row_d;
    logic        vdiv_q, vdiv_d, vret_q, vret_d, vblank_q, vblank_d;
    logic        mahalf_q, mahalf_d, pend_q, pend_d;
    logic [15:0] ma_d, rstart_q, rstart_d;
    logic        vtick, frame_wrap, vdisp, disp_en, vret_rise;

    // a half-rate vertical clock swallows every other line tick
    assign vtick      = hretrace_start & (~mode[cvc_pkg::MODE_HALF_V_BIT] | vdiv_q);
    assign frame_wrap = vtick && vcnt_q == vtotal + 9'h001;
    assign vdisp      = vcnt_q <= vdisp_end;
    assign disp_en    = vdisp & hdisp_in;
    assign vret_rise  = vtick && !vret_q && vcnt_q == vret_start;

    always_comb begin
        vdiv_d   = vdiv_q;
        vcnt_d   = vcnt_q;
        row_d    = row_q;
        vret_d   = vret_q;
        vblank_d = vblank_q;
        mahalf_d = mahalf_q;
        ma_d     = ma_q;
        rstart_d = rstart_q;
        pend_d   = pend_q;
        if (hretrace_start) begin
            vdiv_d = ~vdiv_q;
        end
        if (vtick) begin
            vcnt_d = frame_wrap ? cvc_pkg::LINE_RESET : vcnt_q + 9'h001;
            if (vcnt_q == vret_start) begin
                vret_d = 1'b1;
            end else if (vret_q && vcnt_q[3:0] == regs_q[cvc_pkg::IDX_VRET_END][3:0]) begin
                vret_d = 1'b0;
            end
            if (vcnt_q == vblank_start) begin
                vblank_d = 1'b1;
            end else if (vblank_q && vcnt_q[4:0] == regs_q[cvc_pkg::IDX_VBLANK_END][4:0]) begin
                vblank_d = 1'b0;
            end
        end
        if (disp_en) begin
            mahalf_d = ~mahalf_q;
            if (!mode[cvc_pkg::MODE_HALF_MA_BIT] || mahalf_q) begin
                ma_d = ma_q + 16'h0001;
            end
        end
        if (hretrace_start) begin
            mahalf_d = 1'b0;
            if (row_q == max_scan) begin
                row_d    = cvc_pkg::ROW_RESET;
                rstart_d = rstart_q + {8'h00, regs_q[cvc_pkg::IDX_ROW_PITCH]};
            end else begin
                row_d = row_q + 5'h01;
            end
            ma_d = rstart_d;
        end
        if (vtick && vcnt_q == line_cmp) begin
            rstart_d = cvc_pkg::ADDR_RESET;
            ma_d     = cvc_pkg::ADDR_RESET;
            row_d    = cvc_pkg::ROW_RESET;
        end
        if (frame_wrap) begin
            row_d    = regs_q[cvc_pkg::IDX_ROW_PRESET][4:0];
            rstart_d = disp_origin + start_addr;
            ma_d     = rstart_d;
        end
        // documented behaviour: the clear level wins while the arm bit is low
        if (!irq_arm) begin
            pend_d = 1'b0;
        end else if (vret_rise && mode[cvc_pkg::MODE_RET_EN_BIT]) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vdiv_q   <= 1'b0;
            vcnt_q   <= cvc_pkg::LINE_RESET;
            row_q    <= cvc_pkg::ROW_RESET;
            vret_q   <= 1'b0;
            vblank_q <= 1'b0;
            mahalf_q <= 1'b0;
            ma_q     <= cvc_pkg::ADDR_RESET;
            rstart_q <= cvc_pkg::ADDR_RESET;
            pend_q   <= 1'b0;
        end else if (clk_en) begin
            vdiv_q   <= vdiv_d;
            vcnt_q   <= vcnt_d;
            row_q    <= row_d;
            vret_q   <= vret_d;
            vblank_q <= vblank_d;
            mahalf_q <= mahalf_d;
            ma_q     <= ma_d;
            rstart_q <= rstart_d;
            pend_q   <= pend_d;
        end
    end

    // ------------------------------------------------------------
    // output stage: cursor skew, address mapping, retrace gating
    // ------------------------------------------------------------
    logic [2:0]  cpipe_q, cpipe_d;
    logic        cur_raw, cur_out;
    logic [15:0] maddr_d, maddr_q;
    cvc_pkg::cvc_video_t vid_d, vid_q;
    logic [7:0]  stat_d, stat_q;
    logic        top_bit;

    always_comb begin
        cur_raw = disp_en && ma_q == cur_loc
                  && !regs_q[cvc_pkg::IDX_CURSOR_START][cvc_pkg::CURSOR_OFF_BIT]
                  && cur_start <= cur_end
                  && row_q >= cur_start && row_q < cur_end;
        cpipe_d = {cpipe_q[1:0], cur_raw};
        cur_out = (cur_skew == 2'h0) ? cur_raw : cpipe_q[cur_skew - 2'h1];
        // without 64k wrap the word-mode rotate takes bit 13 instead of 15
        top_bit = mode[cvc_pkg::MODE_WRAP64_BIT] ? ma_q[15] : ma_q[13];
        maddr_d = ma_q;
        if (!mode[cvc_pkg::MODE_BYTE_BIT]) begin
            maddr_d = {ma_q[14:0], top_bit};
        end
        if (!mode[cvc_pkg::MODE_RS14_BIT]) begin
            maddr_d[14] = row_q[1];
        end
        if (!mode[cvc_pkg::MODE_NO_CGA_BIT] && disp_en) begin
            maddr_d[13] = row_q[0];
        end
        vid_d.hretrace  = hretrace_in & mode[cvc_pkg::MODE_RET_EN_BIT];
        vid_d.vretrace  = vret_q & mode[cvc_pkg::MODE_RET_EN_BIT];
        vid_d.vblank    = vblank_q;
        vid_d.disp_en   = disp_en;
        vid_d.cursor    = cur_out;
        vid_d.underline = disp_en && row_q == ul_row;
        vid_d.row_scan  = row_q;
        stat_d = 8'h00;
        stat_d[cvc_pkg::STAT_RETRACE_BIT] = vid_d.hretrace | vid_d.vretrace;
        stat_d[cvc_pkg::STAT_PEN_BIT]     = pen_flag_q;
        stat_d[cvc_pkg::STAT_NVSYNC_BIT]  = ~vid_d.vretrace;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpipe_q <= 3'h0;
            maddr_q <= cvc_pkg::ADDR_RESET;
            vid_q   <= '0;
            stat_q  <= 8'h08;
        end else if (clk_en) begin
            cpipe_q <= cpipe_d;
            maddr_q <= maddr_d;
            vid_q   <= vid_d;
            stat_q  <= stat_d;
        end
    end

    assign video    = vid_q;
    assign mem_addr = maddr_q;
    assign status_o = stat_q;
    assign irq_o    = pend_q;
    assign irq_oe   = ~irq_dis;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    preset_load_a: assert property (clk_en && frame_wrap |=> row_q == $past(regs_q[cvc_pkg::IDX_ROW_PRESET][4:0]))
        else $error("row scan not loaded from preset at frame wrap");
    row_wrap_a: assert property (clk_en && hretrace_start && !frame_wrap && !(vtick && vcnt_q == line_cmp)
                                 && row_q == max_scan |=> row_q == 5'h00)
        else $error("row scan did not clear at max scan line");
    row_step_a: assert property (clk_en && hretrace_start && !frame_wrap && !(vtick && vcnt_q == line_cmp)
                                 && row_q != max_scan |=> row_q == $past(row_q) + 5'h01)
        else $error("row scan did not advance on horizontal retrace");
    cursor_off_a: assert property (regs_q[cvc_pkg::IDX_CURSOR_START][cvc_pkg::CURSOR_OFF_BIT]
                                   || cur_start > cur_end |-> !cur_raw)
        else $error("cursor shown while disabled");
    retrace_gate_a: assert property (clk_en && !mode[cvc_pkg::MODE_RET_EN_BIT]
                                     |=> !video.hretrace && !video.vretrace)
        else $error("retrace output while retrace disabled");
    vret_start_a: assert property (clk_en && vtick && vcnt_q == vret_start |=> vret_q)
        else $error("vertical retrace did not start");
    irq_clear_a: assert property (clk_en && !irq_arm |=> !irq_o)
        else $error("interrupt pending while arm bit low");
    irq_float_a: assert property (irq_dis |-> !irq_oe)
        else $error("interrupt pin driven while disabled");
    irq_fire_a: assert property (clk_en && irq_arm && vret_rise && mode[cvc_pkg::MODE_RET_EN_BIT]
                                 |=> irq_o)
        else $error("no interrupt on vertical retrace");
    pen_cap_a: assert property (clk_en && pen_edge |=> pen_addr_q == $past(ma_q))
        else $error("light pen address not captured");
    split_a: assert property (clk_en && vtick && vcnt_q == line_cmp && !frame_wrap
                              |=> ma_q == 16'h0000 && rstart_q == 16'h0000)
        else $error("line compare did not clear address generator");
    status_ret_a: assert property (clk_en |=> status_o[0] == ($past(vid_d.hretrace) | $past(vid_d.vretrace)))
        else $error("status retrace bit wrong");
    vret_end_a: assert property (clk_en && vtick && vret_q && vcnt_q != vret_start
                                 && vcnt_q[3:0] == regs_q[cvc_pkg::IDX_VRET_END][3:0] |=> !vret_q)
        else $error("vertical retrace did not end");
    vblank_start_a: assert property (clk_en && vtick && vcnt_q == vblank_start |=> vblank_q)
        else $error("vertical blanking did not start");
    disp_end_a: assert property (vcnt_q > vdisp_end |-> !disp_en)
        else $error("display enabled past display end line");
    cursor_rows_a: assert property (row_q < cur_start || row_q >= cur_end |-> !cur_raw)
        else $error("cursor outside its row window");
    underline_a: assert property (clk_en && disp_en && row_q == ul_row |=> video.underline)
        else $error("underline missing on its row");
    word_mode_a: assert property (clk_en && !mode[cvc_pkg::MODE_BYTE_BIT] && mode[cvc_pkg::MODE_WRAP64_BIT]
                                  |=> mem_addr[0] == $past(ma_q[15]))
        else $error("word mode address bit 0 not from counter top bit");
    cga_line_a: assert property (clk_en && !mode[cvc_pkg::MODE_NO_CGA_BIT] && disp_en
                                 |=> mem_addr[13] == $past(row_q[0]))
        else $error("row scan bit 0 not on address bit 13");

    frame_wrap_c: cover property (clk_en && frame_wrap);
    irq_raise_c:  cover property (clk_en && irq_arm && vret_rise ##1 irq_o);
    pen_hit_c:    cover property (clk_en && pen_edge);
    split_c:      cover property (clk_en && vtick && vcnt_q == line_cmp);

endmodule

/* cvc_hsrc.sv */
// horizontal timing source standing in for the monitor-side raster feed
`timescale 1ns/1ps

module cvc_hsrc (
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      hretrace_start,
    output logic      hretrace_in,
    output logic      hdisp_in
);
    // ------------------------------------------------------------
    // 16 character clocks per scan line, retrace at 12..14
    // ------------------------------------------------------------
    logic [3:0] hcnt_q;
    always @(negedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hcnt_q         <= 4'h0;
            hretrace_start <= 1'b0;
            hretrace_in    <= 1'b0;
            hdisp_in       <= 1'b0;
        end else begin
            hcnt_q         <= hcnt_q + 4'h1;
            // one tick per line; every row scan step hangs on it
            hretrace_start <= (hcnt_q == 4'hB);
            hretrace_in    <= (hcnt_q >= 4'hB) && (hcnt_q < 4'hE);
            hdisp_in       <= (hcnt_q == 4'hF) || (hcnt_q < 4'h9);
        end
    end
endmodule

/* cvc_pkg.sv */
// constants and carrier types for the crt vertical, cursor and addressing block
package cvc_pkg;

    // ------------------------------------------------------------
    // register indices behind the data port
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_VERT_TOTAL   = 5'h06;
    localparam logic [4:0] IDX_OVERFLOW     = 5'h07;
    localparam logic [4:0] IDX_ROW_PRESET   = 5'h08;
    localparam logic [4:0] IDX_MAX_SCAN     = 5'h09;
    localparam logic [4:0] IDX_CURSOR_START = 5'h0A;
    localparam logic [4:0] IDX_CURSOR_END   = 5'h0B;
    localparam logic [4:0] IDX_START_HIGH   = 5'h0C;
    localparam logic [4:0] IDX_START_LOW    = 5'h0D;
    localparam logic [4:0] IDX_CURSOR_HIGH  = 5'h0E;
    localparam logic [4:0] IDX_CURSOR_LOW   = 5'h0F;
    localparam logic [4:0] IDX_VRET_START   = 5'h10;
    localparam logic [4:0] IDX_PEN_HIGH     = 5'h10;
    localparam logic [4:0] IDX_VRET_END     = 5'h11;
    localparam logic [4:0] IDX_PEN_LOW      = 5'h11;
    localparam logic [4:0] IDX_VDISP_END    = 5'h12;
    localparam logic [4:0] IDX_ROW_PITCH    = 5'h13;
    localparam logic [4:0] IDX_UNDERLINE    = 5'h14;
    localparam logic [4:0] IDX_VBLANK_START = 5'h15;
    localparam logic [4:0] IDX_VBLANK_END   = 5'h16;
    localparam logic [4:0] IDX_MODE         = 5'h17;
    localparam logic [4:0] IDX_LINE_COMPARE = 5'h18;
    localparam int         REG_COUNT        = 25;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OVF_VT_BIT       = 0;
    localparam int OVF_VDE_BIT      = 1;
    localparam int OVF_VRS_BIT      = 2;
    localparam int OVF_VBS_BIT      = 3;
    localparam int OVF_LC_BIT       = 4;
    localparam int CURSOR_OFF_BIT   = 5;
    localparam int SKEW_LSB         = 5;
    localparam int IRQ_DISABLE_BIT  = 5;
    localparam int IRQ_ARM_BIT      = 4;
    localparam int MODE_RET_EN_BIT  = 7;
    localparam int MODE_BYTE_BIT    = 6;
    localparam int MODE_WRAP64_BIT  = 5;
    localparam int MODE_HALF_MA_BIT = 3;
    localparam int MODE_HALF_V_BIT  = 2;
    localparam int MODE_RS14_BIT    = 1;
    localparam int MODE_NO_CGA_BIT  = 0;
    localparam int STAT_RETRACE_BIT = 0;
    localparam int STAT_PEN_BIT     = 1;
    localparam int STAT_NVSYNC_BIT  = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_RESET    = 8'h00;
    localparam logic [15:0] ADDR_RESET   = 16'h0000;
    localparam logic [8:0]  LINE_RESET   = 9'h000;
    localparam logic [4:0]  ROW_RESET    = 5'h00;

    typedef struct packed {
        logic       idx_wr;
        logic       dat_wr;
        logic       dat_rd;
        logic [7:0] wdata;
    } cvc_host_req_t;

    typedef struct packed {
        logic       hretrace;
        logic       vretrace;
        logic       vblank;
        logic       disp_en;
        logic       cursor;
        logic       underline;
        logic [4:0] row_scan;
    } cvc_video_t;

endpackage

/* testbench.sv */
// self-checking bench for the crt vertical, cursor and addressing block
`timescale 1ns/1ps

module testbench;
    logic                   clk = 1'b0;
    logic                   sys_rst = 1'b1;
    logic                   clk_en = 1'b1;
    logic                   pen_strobe = 1'b0;
    logic [15:0]            disp_origin = 16'h0000;
    cvc_pkg::cvc_host_req_t host_req = '0;
    logic [7:0]             io_rdata;
    logic [7:0]             status_o;
    logic                   hs, hr, hd, irq_o, irq_oe;
    cvc_pkg::cvc_video_t    video;
    logic [15:0]            mem_addr;
    int                     errors = 0;
    int                     checked = 0;
    logic [7:0]             v, rv;
    logic                   bad;
    logic [3:0]             seen;

    always #5 clk = ~clk;

    cvc_hsrc i_cvc_hsrc (.clk(clk), .sys_rst(sys_rst), .hretrace_start(hs), .hretrace_in(hr), .hdisp_in(hd));
    cvc_crtc i_cvc_crtc (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .host_req(host_req),
        .io_rdata(io_rdata), .status_o(status_o), .hretrace_start(hs), .hretrace_in(hr),
        .hdisp_in(hd), .disp_origin(disp_origin), .pen_strobe(pen_strobe), .video(video),
        .mem_addr(mem_addr), .irq_o(irq_o), .irq_oe(irq_oe));

    // ------------------------------------------------------------
    // host port tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sel(input logic [4:0] idx);
        @(negedge clk) host_req.idx_wr = 1'b1;
        host_req.wdata = {3'h0, idx};
        @(negedge clk) host_req.idx_wr = 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        sel(idx);
        host_req.dat_wr = 1'b1;
        host_req.wdata  = d;
        @(negedge clk) host_req.dat_wr = 1'b0;
    endtask

    task automatic rd(input logic [4:0] idx, output logic [7:0] d);
        sel(idx);
        host_req.dat_rd = 1'b1;
        @(negedge clk) host_req.dat_rd = 1'b0;
        // read data registered; it stands until the next read
        @(negedge clk) d = io_rdata;
    endtask

    task automatic test_done;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h282ebc67));
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk(status_o, 16'h0008);
        chk(irq_oe, 1'b1);
        for (int i = 12; i < 16; i++) begin
            v = $urandom;
            wr(i[4:0], v);
            rd(i[4:0], rv);
            chk(rv, v);
        end
        wr(5'h19, 8'hFF);
        rd(5'h0F, rv);
        chk(rv, v);
        rd(cvc_pkg::IDX_MAX_SCAN, rv);
        chk(rv, 8'h00);
        wr(cvc_pkg::IDX_VERT_TOTAL, 8'h10);
        wr(cvc_pkg::IDX_MAX_SCAN, 8'h03);
        wr(cvc_pkg::IDX_VRET_START, 8'h04);
        wr(cvc_pkg::IDX_VRET_END, 8'h16);
        wr(cvc_pkg::IDX_VDISP_END, 8'h0C);
        bad = 1'b0;
        repeat (600) begin
            @(negedge clk);
            if (video.hretrace !== 1'b0 || video.vretrace !== 1'b0 || video.row_scan > 5'h03) bad = 1'b1;
        end
        chk(bad, 1'b0);
        wr(cvc_pkg::IDX_MODE, 8'hA0);
        for (int i = 0; i < 1000 && video.vretrace !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        chk(video.vretrace, 1'b1);
        chk({status_o[3], status_o[0]}, 2'b01);
        for (int i = 0; i < 1000 && irq_o !== 1'b1; i++) @(negedge clk);
        chk(irq_o, 1'b1);
        wr(cvc_pkg::IDX_VRET_END, 8'h06);
        repeat (3) @(negedge clk);
        chk(irq_o, 1'b0);
        wr(cvc_pkg::IDX_VRET_END, 8'h26);
        chk(irq_oe, 1'b0);
        pen_strobe = 1'b1;
        repeat (6) @(negedge clk);
        chk(status_o[1], 1'b1);
        rd(cvc_pkg::IDX_PEN_LOW, rv);
        pen_strobe = 1'b0;
        repeat (2) @(negedge clk);
        chk(status_o[1], 1'b0);
        // cursor rows 0..1 at a random early address, underline on row 2
        wr(cvc_pkg::IDX_CURSOR_HIGH, 8'h00);
        wr(cvc_pkg::IDX_CURSOR_LOW, 8'($urandom_range(9)));
        wr(cvc_pkg::IDX_CURSOR_START, 8'h00);
        wr(cvc_pkg::IDX_CURSOR_END, 8'h02);
        wr(cvc_pkg::IDX_UNDERLINE, 8'h02);
        wr(cvc_pkg::IDX_VBLANK_START, 8'h0E);
        wr(cvc_pkg::IDX_VBLANK_END, 8'h10);
        seen = 4'h0;
        bad  = 1'b0;
        repeat (600) begin
            @(negedge clk);
            seen |= {video.cursor, video.underline, video.vblank, ~video.vblank};
            if ((video.cursor && video.row_scan > 5'h01) || (video.underline && video.row_scan != 5'h02)) bad = 1'b1;
            if (video.disp_en && mem_addr[13] !== video.row_scan[0]) bad = 1'b1;
        end
        chk(seen, 4'hF);
        chk(bad, 1'b0);
        for (int k = 0; k < 2; k++) begin
            wr(cvc_pkg::IDX_CURSOR_START, (k == 0) ? 8'h20 : 8'h03);
            bad = 1'b0;
            repeat (300) begin
                @(negedge clk);
                bad |= video.cursor;
            end
            chk(bad, 1'b0);
        end
        test_done();
    end

    initial begin
        #400us;
        errors++;
        test_done();
    end
endmodule
